// ==== dram_map_pkg.sv ====
/*
 * Shared constants and carrier types for the DRAM address mux and
 * page-policy block: register offsets, field positions, reset values,
 * row attribute layout and the per-request answer.
 * Assumes a single 10 MHz system clock and an 8-bit register port.
 */
package dram_map_pkg;

   // register offsets on the 8-bit register port
   localparam logic [7:0] OFS_SDRAM_CTRL = 8'h54;
   localparam logic [7:0] OFS_ROW_ATTR = 8'h60;
   localparam logic [7:0] OFS_TOP_DRAM = 8'h61;
   localparam logic [7:0] OFS_GAP_CTRL = 8'h62;
   localparam logic [7:0] OFS_STATUS = 8'h63;
   localparam logic [7:0] OFS_DRAM_CTRL = 8'h67;

   // field positions
   localparam int SC_INIT_BIT = 0;
   localparam int SC_WIDE64_BIT = 1;
   localparam int DC_DUP_MA_BIT = 2;
   localparam int DC_PAGE_KEEP_BIT = 4;
   localparam int GAP_EN_BIT = 0;
   localparam int GAP_SEL_BIT = 1;
   localparam int RA_TYPE_LSB = 3;
   localparam int RA_CW_LSB = 5;

   // reset values
   localparam logic [7:0] RST_DRAM_CTRL = 8'h00;
   localparam logic [7:0] RST_SDRAM_CTRL = 8'h00;
   localparam logic [7:0] RST_TOP_DRAM = 8'hFF;
   localparam logic [7:0] RST_GAP_CTRL = 8'h00;

   // address windows, in units of the compared address slice
   localparam logic [14:0] VIDEO_128K = 15'h0005;
   localparam logic [14:0] GAP_LOW_128K = 15'h0004;
   localparam logic [11:0] GAP_HIGH_1M = 12'h00F;

   localparam int NUM_ROWS = 6;

   typedef enum logic [1:0] {
      RT_FPM = 2'b00,
      RT_EDO = 2'b01,
      RT_SDRAM = 2'b10
   } row_type_t;

   // column width code: 0 = 8 bits, 1 = 9, 2 = 10, 3 = 11 or more
   typedef struct packed {
      logic [1:0] cw;
      row_type_t rtype;
   } row_attr_t;

   typedef struct packed {
      logic valid;
      logic fwd_pci;
      logic non_cache;
      logic hit;
      logic page_miss;
      logic row_miss;
      row_type_t rtype;
   } ans_t;

endpackage

// ==== row_attr_mem.sv ====
/*
 * Small per-row attribute memory, one word per DRAM row.
 * Written from the register port, read by the request pipeline;
 * read data come out of a register one cycle after the address.
 */
`timescale 1ns/1ps
module row_attr_mem #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 6,
   parameter int AW = 3
) (
   // clock
   input wire logic sys_clk,
   // write side
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // read side
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata_q
);
   logic [WIDTH-1:0] mem [DEPTH];

   // no reset here: the owner keeps a valid bit per row instead
   always_ff @(posedge sys_clk) begin
      if (we && (int'(waddr) < DEPTH)) begin
         mem[waddr] <= wdata;
      end
      rdata_q <= (int'(raddr) < DEPTH) ? mem[raddr] : '0;
   end
endmodule

// ==== dram_addr_map.sv ====
/*
 * Combinational translation of host/PCI address bits 26..3 into the
 * row or column phase of the multiplexed DRAM address.
 * Assumes the caller registers the result before it reaches a pin.
 */
`timescale 1ns/1ps
module dram_addr_map
   import dram_map_pkg::*;
(
   // access address and phase
   input wire logic [26:3] a,
   input wire logic col_phase,
   // row and mode configuration
   input wire row_attr_t attr,
   input wire logic sdram_init,
   input wire logic wide64,
   // mapped address
   output logic [13:0] ma
);
   logic sd;

   assign sd = (attr.rtype == RT_SDRAM);

   // one phase or the other, picked per access
   always_comb begin
      ma = '0;
      if (!col_phase) begin
         ma[10:0] = a[22:12];
         ma[11] = a[11];
         ma[12] = a[23];
         ma[13] = a[24];
      end else begin
         ma[7:0] = a[10:3];
         unique case (attr.cw)
            2'b00: ma[8] = a[11];
            2'b01: ma[8] = a[22];
            2'b10: ma[8] = a[23];
            2'b11: ma[8] = a[25];
         endcase
         ma[9] = (attr.cw == 2'b00) ? a[11] : ((attr.cw == 2'b01) ? a[24] : a[26]);
         ma[10] = sd ? sdram_init : ((attr.cw == 2'b00) ? a[11] : a[25]);
         // bank selects on 11 and 12
         ma[11] = (sd || attr.cw != 2'b11) ? a[11] : a[26];
         ma[12] = a[23];
      end
      // upper two lines only when wide
      if (!wide64) begin
         ma[13:12] = 2'b00;
      end
   end
endmodule

// ==== dram_page_ctrl.sv ====
/*
 * DRAM address translation and page policy.
 * Assumes request, idle and ownership inputs come from logic on sys_clk,
 * and that row selection from the boundary registers is done outside.
 */
// The register offsets and strobed register access are this design's own decisions.
// Notes on behaviour
// - 12-bit address bus, 14 with 64-Mbit
// - row phase carries A12-A22, A11, A23, A24
// - addresses from A26..A3; column low is A3-A10
// - SDRAM column bit 10: init high, else low
// - page is always 2 KB
// - SDRAM bank selects on bits 11, 12
// - keep-open policy: close only on miss
// - default policy: open while host busy or PCI
// - unconfigured rows run fast page mode
// - duplicate address bits 0,1 on enable pins
// - above top, video (except under SMM), gap go to PCI, uncached
// - DRAM under video or gap never remapped
// - type chosen separately for each row
// - wide mode turns strobes 4,5 into addresses
`timescale 1ns/1ps
module dram_page_ctrl
   import dram_map_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // access requests
   input wire logic req_valid,
   input wire logic [31:3] req_addr,
   input wire logic [2:0] req_row,
   input wire logic smm_active,
   output ans_t ans,
   // bus activity
   input wire logic host_idle,
   input wire logic pci_owns_bus,
   output logic precharge,
   // memory address pins
   input wire logic col_phase,
   input wire logic cke_level,
   input wire logic [5:4] row_strobe_n,
   output logic [13:0] mem_addr_bus,
   output logic clk_enable_copy_a,
   output logic clk_enable_copy_b,
   output logic row_strobe4_pin,
   output logic row_strobe5_pin
);
   typedef enum logic [0:0] {
      PG_CLOSED = 1'b0,
      PG_OPEN = 1'b1
   } pg_state_t;

   typedef struct packed {
      logic [7:0] dctl;
      logic [7:0] sctl;
      logic [7:0] tod;
      logic [7:0] gap;
      logic [7:0] rdata;
      logic [NUM_ROWS-1:0] rvalid;
      logic s1_v;
      logic [31:3] s1_addr;
      logic [2:0] s1_row;
      pg_state_t pg;
      logic [2:0] open_row;
      logic [26:11] open_page;
      logic [26:3] cur_addr;
      row_attr_t cur_attr;
      ans_t ans;
      logic pre;
      logic [13:0] ma;
      logic cka;
      logic ckb;
      logic r4;
      logic r5;
   } st_t;

   st_t st_q;
   st_t st_d;
   row_attr_t mem_rd;
   row_attr_t s1_attr;
   logic [13:0] ma_map;
   logic attr_we;
   logic above_top;
   logic in_video;
   logic in_gap;
   logic to_pci;
   logic same_row;
   logic same_page;

   // row type written through one command byte
   assign attr_we = reg_wr && (reg_addr == OFS_ROW_ATTR);

   row_attr_mem #(
      .WIDTH(4),
      .DEPTH(NUM_ROWS),
      .AW(3)
   ) u_attr (
      .sys_clk(sys_clk),
      .we(attr_we),
      .waddr(reg_wdata[2:0]),
      .wdata(reg_wdata[RA_CW_LSB+1:RA_TYPE_LSB]),
      .raddr(req_row),
      .rdata_q(mem_rd)
   );

   dram_addr_map u_map (
      .a(st_q.cur_addr),
      .col_phase(col_phase),
      .attr(st_q.cur_attr),
      .sdram_init(st_q.sctl[SC_INIT_BIT]),
      .wide64(st_q.sctl[SC_WIDE64_BIT]),
      .ma(ma_map)
   );

   // unwritten rows fall back to FPM
   assign s1_attr = st_q.rvalid[st_q.s1_row] ? mem_rd : row_attr_t'(4'h0);

   // decode of the regions that bypass DRAM
   assign above_top = (|st_q.s1_addr[31:28]) || (st_q.s1_addr[27:20] >= st_q.tod);
   assign in_video = (st_q.s1_addr[31:17] == VIDEO_128K);
   assign in_gap = st_q.gap[GAP_EN_BIT] &&
      (st_q.gap[GAP_SEL_BIT] ? (st_q.s1_addr[31:20] == GAP_HIGH_1M)
                             : (st_q.s1_addr[31:17] == GAP_LOW_128K));
   // no remap; only SMM reaches DRAM under video
   assign to_pci = above_top || (in_video && !smm_active) || in_gap;

   // page compare fixed at 2 KB
   assign same_row = (st_q.open_row == st_q.s1_row);
   assign same_page = same_row && (st_q.open_page == st_q.s1_addr[26:11]);

   // next state of the whole block
   always_comb begin
      st_d = st_q;
      st_d.rdata = 8'h00;
      st_d.ans = '0;
      st_d.pre = 1'b0;
      // register writes
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_DRAM_CTRL: st_d.dctl = reg_wdata;
            OFS_SDRAM_CTRL: st_d.sctl = reg_wdata;
            OFS_TOP_DRAM: st_d.tod = reg_wdata;
            OFS_GAP_CTRL: st_d.gap = reg_wdata;
            OFS_ROW_ATTR: begin
               if (int'(reg_wdata[2:0]) < NUM_ROWS) begin
                  st_d.rvalid[reg_wdata[2:0]] = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // register reads, data in the following cycle only
      if (reg_rd) begin
         unique case (reg_addr)
            OFS_DRAM_CTRL: st_d.rdata = st_q.dctl;
            OFS_SDRAM_CTRL: st_d.rdata = st_q.sctl;
            OFS_TOP_DRAM: st_d.rdata = st_q.tod;
            OFS_GAP_CTRL: st_d.rdata = st_q.gap;
            OFS_STATUS: st_d.rdata = {2'b00, st_q.cur_attr.rtype, st_q.open_row,
                                      st_q.pg == PG_OPEN};
            default: st_d.rdata = 8'h00;
         endcase
      end
      // stage 1 waits one cycle for the attribute memory
      st_d.s1_v = req_valid;
      if (req_valid) begin
         st_d.s1_addr = req_addr;
         st_d.s1_row = req_row;
      end
      if (st_q.s1_v) begin
         st_d.ans.valid = 1'b1;
         st_d.ans.fwd_pci = to_pci;
         st_d.ans.non_cache = to_pci;
         if (!to_pci) begin
            // each access carries its own row type
            st_d.ans.rtype = s1_attr.rtype;
            st_d.cur_attr = s1_attr;
            st_d.cur_addr = st_q.s1_addr[26:3];
            // open page stays until a miss
            st_d.ans.hit = (st_q.pg == PG_OPEN) && same_page;
            st_d.ans.page_miss = (st_q.pg == PG_OPEN) && same_row && !same_page;
            st_d.ans.row_miss = (st_q.pg == PG_OPEN) && !same_row;
            st_d.pg = PG_OPEN;
            st_d.open_row = st_q.s1_row;
            st_d.open_page = st_q.s1_addr[26:11];
         end
      end else if (st_q.pg == PG_OPEN && !st_q.dctl[DC_PAGE_KEEP_BIT]) begin
         if (host_idle && !pci_owns_bus) begin
            st_d.pg = PG_CLOSED;
            st_d.pre = 1'b1;
         end
      end
      st_d.ma = ma_map;
      st_d.cka = st_q.dctl[DC_DUP_MA_BIT] ? ma_map[0] : cke_level;
      st_d.ckb = st_q.dctl[DC_DUP_MA_BIT] ? ma_map[1] : cke_level;
      // strobes 4 and 5 become BA1 and bit 13
      st_d.r4 = st_q.sctl[SC_WIDE64_BIT] ? ma_map[12] : row_strobe_n[4];
      st_d.r5 = st_q.sctl[SC_WIDE64_BIT] ? ma_map[13] : row_strobe_n[5];
   end

   // single register of all state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '0;
         st_q.dctl <= RST_DRAM_CTRL;
         st_q.sctl <= RST_SDRAM_CTRL;
         st_q.tod <= RST_TOP_DRAM;
         st_q.gap <= RST_GAP_CTRL;
         st_q.pg <= PG_CLOSED;
         st_q.cka <= 1'b0;
         st_q.ckb <= 1'b0;
         st_q.r4 <= 1'b1;
         st_q.r5 <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state register
   assign reg_rdata = st_q.rdata;
   assign ans = st_q.ans;
   assign precharge = st_q.pre;
   assign mem_addr_bus = st_q.ma;
   assign clk_enable_copy_a = st_q.cka;
   assign clk_enable_copy_b = st_q.ckb;
   assign row_strobe4_pin = st_q.r4;
   assign row_strobe5_pin = st_q.r5;

   // EDO data hold lets the strobe rise early; timing is outside
   // this block, so it only shapes the sequencer that uses our address

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // answer two cycles after a request
   a_answer_delay: assert property (req_valid |-> ##2 ans.valid)
      else $error("answer not two cycles after request");

   // narrow bus leaves the top lines low
   a_bus_narrow_top: assert property (
      $past(!st_q.sctl[SC_WIDE64_BIT]) |-> mem_addr_bus[13:12] == 2'b00)
      else $error("upper address lines driven in narrow mode");

   // row phase carries A22..A12 on bits 10..0
   a_row_phase_map: assert property (
      $past(!col_phase) |-> mem_addr_bus[10:0] == $past(st_q.cur_addr[22:12]))
      else $error("row phase mapping wrong");

   // column phase low byte
   a_col_low_map: assert property (
      $past(col_phase) |-> mem_addr_bus[7:0] == $past(st_q.cur_addr[10:3]))
      else $error("column phase low bits wrong");

   // mode level on bit 10 for SDRAM columns
   a_sdram_mode_bit: assert property (
      $past(col_phase && st_q.cur_attr.rtype == RT_SDRAM)
      |-> mem_addr_bus[10] == $past(st_q.sctl[SC_INIT_BIT]))
      else $error("SDRAM column bit 10 level wrong");

   // same 2 KB page on the open row is a hit
   a_page_hit_2k: assert property (
      st_q.s1_v && !to_pci && st_q.pg == PG_OPEN && same_row
      && st_q.open_page == st_q.s1_addr[26:11] |=> ans.hit && !ans.page_miss)
      else $error("2 KB page hit missed");

   // keep-open policy holds the page through idle
   a_keep_open: assert property (
      st_q.dctl[DC_PAGE_KEEP_BIT] && st_q.pg == PG_OPEN && !st_q.s1_v
      |=> st_q.pg == PG_OPEN && !precharge)
      else $error("page closed under keep-open policy");

   // default policy keeps page while bus busy
   a_busy_open: assert property (
      !st_q.dctl[DC_PAGE_KEEP_BIT] && st_q.pg == PG_OPEN && !st_q.s1_v
      && (!host_idle || pci_owns_bus) |=> st_q.pg == PG_OPEN)
      else $error("page closed while bus busy");

   // default policy precharges when idle
   a_idle_close: assert property (
      !st_q.dctl[DC_PAGE_KEEP_BIT] && st_q.pg == PG_OPEN && !st_q.s1_v
      && host_idle && !pci_owns_bus |=> precharge ##1 !precharge)
      else $error("idle bus did not precharge once");

   // enable pins mirror address bits 0 and 1
   a_dup_addr_pins: assert property (
      $past(st_q.dctl[DC_DUP_MA_BIT])
      |-> clk_enable_copy_a == mem_addr_bus[0] && clk_enable_copy_b == mem_addr_bus[1])
      else $error("duplicate address pins wrong");

   // above-top and gap regions forwarded and uncached
   a_fwd_pci: assert property (
      st_q.s1_v && (above_top || (in_gap && !in_video)) |=> ans.fwd_pci && ans.non_cache)
      else $error("bypass region not forwarded");

   // strobe pins carry bank and top address in wide mode
   a_wide_strobes: assert property (
      $past(st_q.sctl[SC_WIDE64_BIT])
      |-> row_strobe4_pin == mem_addr_bus[12] && row_strobe5_pin == mem_addr_bus[13])
      else $error("wide mode strobe pins wrong");
endmodule

// ==== edo_row_model.sv ====
/*
 * Behavioural EDO memory row on the far side of the address mux.
 * Assumes the bench drives the row and column strobes in place of the
 * sequencer, after the address bus has settled.
 */
`timescale 1ns/1ps
module edo_row_model (
   // strobes
   input wire logic ras_n,
   input wire logic cas_n,
   // address from the block
   input wire logic [13:0] mem_addr_bus,
   // read data: row and column seen
   output logic [27:0] rd_data
);
   logic [13:0] row_lat;

   // row address taken as the row strobe falls
   always @(negedge ras_n) begin
      row_lat = mem_addr_bus;
   end

   // data held to next strobe
   // data move only on a falling column strobe, so an early rise is harmless
   always @(negedge cas_n) begin
      rd_data = {row_lat, mem_addr_bus};
   end
endmodule

// ==== testbench.sv ====
/*
 * Self-checking bench for the DRAM address mux and page policy block.
 * Assumes the package, the design files and the EDO row model are
 * compiled first; one 10 MHz clock, synchronous reset.
 */
`timescale 1ns/1ps
module testbench;
   import dram_map_pkg::*;
   localparam logic [31:0] ADR = 32'h01A5_5D68;
   localparam logic [31:0] PA = 32'h0010_0000;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0, smm_active = 1'b0;
   logic [31:3] req_addr = '0;
   logic [2:0] req_row = 3'h0;
   logic host_idle = 1'b0, pci_owns_bus = 1'b0, col_phase = 1'b0, cke_level = 1'b0;
   logic [5:4] row_strobe_n = 2'h3;
   logic precharge, clk_enable_copy_a, clk_enable_copy_b, row_strobe4_pin, row_strobe5_pin;
   logic [13:0] mem_addr_bus;
   logic [27:0] rd_data;
   logic ras_n = 1'b1, cas_n = 1'b1;
   ans_t ans, got;
   int err_total = 0, num_checks = 0;

   dram_page_ctrl DUT (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .req_valid, .req_addr, .req_row, .smm_active, .ans, .host_idle, .pci_owns_bus,
      .precharge, .col_phase, .cke_level, .row_strobe_n, .mem_addr_bus, .clk_enable_copy_a,
      .clk_enable_copy_b, .row_strobe4_pin, .row_strobe5_pin);
   edo_row_model row_model (.ras_n, .cas_n, .mem_addr_bus, .rd_data);

   // 100 ns clock
   always #50 sys_clk = ~sys_clk;

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   // flags: valid, hit, page miss, row miss
   task automatic chk_ans(input string what, input logic [3:0] exp);
      chk(what, {12'h000, exp}, {12'h000, got.valid, got.hit, got.page_miss, got.row_miss});
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // answer is taken in the one cycle it stands
   task automatic req(input logic [31:0] a, input logic [2:0] r);
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_addr <= a[31:3];
      req_row <= r;
      @(posedge sys_clk);
      req_valid <= 1'b0;
      tick(1);
      got = ans;
   endtask

   task automatic count_pre(input int n, output int c);
      c = 0;
      repeat (n) begin
         tick(1);
         if (precharge === 1'b1) c++;
      end
   endtask

   function automatic logic [13:0] row_ma(input logic [31:0] a, input logic w);
      return {w & a[24], w & a[23], a[11], a[22:12]};
   endfunction

   function automatic logic [13:0] col_ma(input logic [31:0] a, input logic w, input logic v);
      return {1'b0, w & a[23], a[11], v, a[11], a[11], a[10:3]};
   endfunction

   task automatic t_reset;
      logic [7:0] d;
      logic [7:0] ofs [7] = '{8'h67, 8'h54, 8'h61, 8'h62, 8'h60, 8'h63, 8'h70};
      logic [7:0] exp [7] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
      wr(8'h63, 8'hFF);
      wr(8'h70, 8'hFF);
      for (int i = 0; i < 7; i++) begin
         rd(ofs[i], d);
         chk("register", {8'h00, exp[i]}, {8'h00, d});
      end
   endtask

   task automatic t_map(input logic w);
      logic [13:0] rm;
      logic [13:0] cm;
      rm = row_ma(ADR, w);
      cm = col_ma(ADR, w, ADR[11]);
      wr(8'h54, {6'h00, w, 1'b0});
      @(posedge sys_clk);
      col_phase <= 1'b0;
      row_strobe_n <= 2'h1;
      req(ADR, 3'h0);
      tick(2);
      chk("row address", {2'h0, rm}, {2'h0, mem_addr_bus});
      chk("strobe pins", {14'h0, w ? rm[13:12] : 2'h1},
         {14'h0, row_strobe5_pin, row_strobe4_pin});
      @(posedge sys_clk);
      ras_n <= 1'b0;
      col_phase <= 1'b1;
      tick(2);
      chk("column address", {3'h0, cm[12:0]}, {3'h0, mem_addr_bus[12:0]});
      @(posedge sys_clk);
      cas_n <= 1'b0;
      @(posedge sys_clk);
      cas_n <= 1'b1;
      ras_n <= 1'b1;
      col_phase <= 1'b0;
      tick(3);
      chk("held data", {3'h0, cm[12:0]}, {3'h0, rd_data[12:0]});
      chk("row in memory", {2'h0, rm}, {2'h0, rd_data[27:14]});
   endtask

   task automatic t_sdram;
      logic [13:0] cm;
      wr(8'h60, 8'h11);
      wr(8'h60, 8'h0A);
      wr(8'h54, 8'h01);
      @(posedge sys_clk);
      col_phase <= 1'b1;
      req(ADR, 3'h1);
      chk("sdram type", {14'h0, RT_SDRAM}, {14'h0, got.rtype});
      tick(2);
      cm = col_ma(ADR, 1'b0, 1'b1);
      chk("init column", {2'h0, cm}, {2'h0, mem_addr_bus});
      wr(8'h54, 8'h02);
      tick(2);
      cm = col_ma(ADR, 1'b1, 1'b0);
      chk("bank column", {3'h0, cm[12:0]}, {3'h0, mem_addr_bus[12:0]});
      req(ADR, 3'h2);
      chk("edo type", {14'h0, RT_EDO}, {14'h0, got.rtype});
      req(ADR, 3'h4);
      chk("default type", {14'h0, RT_FPM}, {14'h0, got.rtype});
      wr(8'h54, 8'h00);
   endtask

   // column codes 1..3 on an EDO row: upper column bits 11..8 for ADR
   task automatic t_colw;
      logic [3:0] exp [3] = '{4'hA, 4'h9, 4'h0};
      @(posedge sys_clk);
      col_phase <= 1'b1;
      for (int i = 1; i < 4; i++) begin
         wr(8'h60, {1'b0, 2'(i), 2'b01, 3'h5});
         req(ADR, 3'h5);
         tick(2);
         chk("column code", {12'h000, exp[i-1]}, {12'h000, mem_addr_bus[11:8]});
      end
   endtask

   task automatic t_page;
      logic [7:0] d;
      int c;
      @(posedge sys_clk);
      host_idle <= 1'b1;
      tick(3);
      @(posedge sys_clk);
      host_idle <= 1'b0;
      req(PA, 3'h0);
      chk_ans("closed page", 4'h8);
      req(PA + 32'h400, 3'h0);
      chk_ans("same page", 4'hC);
      req(PA + 32'h800, 3'h0);
      chk_ans("next page", 4'hA);
      req(PA + 32'h800, 3'h3);
      chk_ans("other row", 4'h9);
      rd(8'h63, d);
      chk("open status", 16'h0007, {8'h00, d});
      @(posedge sys_clk);
      host_idle <= 1'b1;
      pci_owns_bus <= 1'b1;
      count_pre(6, c);
      chk("precharge pci", 16'h0000, c[15:0]);
      @(posedge sys_clk);
      pci_owns_bus <= 1'b0;
      count_pre(6, c);
      chk("precharge idle", 16'h0001, c[15:0]);
      rd(8'h63, d);
      chk("closed status", 16'h0000, {15'h0, d[0]});
      wr(8'h67, 8'h10);
      req(PA, 3'h0);
      count_pre(8, c);
      chk("precharge kept", 16'h0000, c[15:0]);
      req(PA, 3'h0);
      chk_ans("kept page", 4'hC);
      req(PA + 32'h800, 3'h0);
      chk_ans("kept miss", 4'hA);
      @(posedge sys_clk);
      host_idle <= 1'b0;
      wr(8'h67, 8'h00);
   endtask

   task automatic t_pci;
      logic [31:0] a [7] = '{32'h0200_0000, 32'h00F0_0000, 32'h00F0_0000, 32'h0008_0000,
         32'h0008_0000, 32'h000A_0000, 32'h000A_0000};
      logic [7:0] gap [7] = '{8'h00, 8'h00, 8'h03, 8'h01, 8'h00, 8'h00, 8'h00};
      logic [6:0] smm = 7'h40;
      logic [6:0] fwd = 7'h2D;
      wr(8'h61, 8'h10);
      for (int i = 0; i < 7; i++) begin
         wr(8'h62, gap[i]);
         @(posedge sys_clk);
         smm_active <= smm[i];
         req(a[i], 3'h0);
         chk("forward", {14'h0, fwd[i], fwd[i]}, {14'h0, got.fwd_pci, got.non_cache});
      end
      wr(8'h61, 8'hFF);
      @(posedge sys_clk);
      smm_active <= 1'b0;
   endtask

   task automatic t_dup;
      @(posedge sys_clk);
      col_phase <= 1'b0;
      cke_level <= 1'b1;
      req(PA, 3'h0);
      tick(2);
      chk("enable pins", 16'h0003, {14'h0, clk_enable_copy_b, clk_enable_copy_a});
      wr(8'h67, 8'h04);
      tick(2);
      chk("dup address", 16'h0000, {14'h0, clk_enable_copy_b, clk_enable_copy_a});
      @(posedge sys_clk);
      cke_level <= 1'b0;
      req(PA + 32'h2000, 3'h0);
      tick(2);
      chk("dup address", 16'h0002, {14'h0, clk_enable_copy_b, clk_enable_copy_a});
      wr(8'h67, 8'h00);
   endtask

   task automatic conclude;
      $display("checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      tick(5);
      chk("reset bus", 16'h0000, {2'h0, mem_addr_bus});
      chk("reset pins", 16'h0003, {14'h0, row_strobe5_pin, row_strobe4_pin});
      @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_map(1'b0);
      t_map(1'b1);
      t_sdram();
      t_colw();
      t_page();
      t_pci();
      t_dup();
      conclude();
   end

   // watchdog: the run needs well under 1000 cycles
   initial begin
      #300000;
      err_total++;
      conclude();
   end
endmodule
